/* rtl/msi_core.sv */
/*
 Module status and interrupt core: flag latching with clear on read,
 masks, interrupt pin, management init window and rate select.
 Assumes an APB master on pclk and flag conditions arriving
 asynchronously from the optical front end.
*/
// What this block does
// - finish init within 2000 ms
// - pull interrupt low within 200 ms
// - release interrupt within 500 us after read
// - latch receive loss, interrupt within 100 ms
// - fast mode clears loss status in 3 ms
// - latch transmit fault, interrupt within 200 ms
// - latch other flags, interrupt within 200 ms
// - set mask stops interrupt within 100 ms
// - cleared mask resumes interrupt within 100 ms
// - apply rate select within 100 ms
// - fifteen read-only flags, fifteen mask bytes
`timescale 1ns/1ps
module msi_core
    import msi_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_MAX_CYC
)(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Module pins
    input  wire logic                  module_reset_n,
    output logic                       interrupt_out_n,
    // Front end
    input  wire logic [NBYTE*8-1:0]    cond_in,
    output logic                       management_init_state,
    output logic      [7:0]            rate_sel,
    output logic                       fast_mode,
    // System interrupt
    output logic                       irq
);
    localparam int IW = $clog2(INIT_CYCLES + 1);
    initial
    begin
        if (INIT_CYCLES < 1 || INIT_CYCLES > INIT_MAX_CYC)
            $error("INIT_CYCLES out of range");
    end

    typedef logic [NBYTE-1:0][7:0] msi_bytes_t;

    typedef struct packed {
        msi_bytes_t     s1;
        msi_bytes_t     s2;
        msi_bytes_t     flag;
        msi_bytes_t     mask;
        logic [IW-1:0]  icnt;
        logic           init;
        logic           int_n;
        logic           fast;
        logic [7:0]     rate;
        logic [IRQ_W-1:0] ist;
        logic [IRQ_W-1:0] imsk;
        logic [7:0]     rdata;
        logic           err;
    } msi_core_st_t;

    msi_core_st_t st_reg;
    msi_core_st_t st_next;

    msi_rst_if rst_c ();

    msi_rst_filter #(
        .MIN_CYC (RESET_MIN_CYC)
    ) u_rst_filter (
        .pclk           (pclk),
        .presetn        (presetn),
        .module_reset_n (module_reset_n),
        .rst            (rst_c.src)
    );

    // ==========================================================
    // Address decode
    // ==========================================================
    logic [7:0] idx;
    logic       hi_ok;
    logic       is_flag;
    logic       is_mask;
    logic [7:0] fi;
    logic [7:0] mi;
    logic       setup;
    logic       wr_acc;
    logic       rd_acc;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;

    assign idx     = paddr[9:2];
    assign hi_ok   = (paddr[ADDR_W-1:10] == '0) & (paddr[1:0] == 2'h0);
    assign is_flag = hi_ok & (idx >= FLAG_IDX0) & (idx <= FLAG_LAST);
    assign is_mask = hi_ok & (idx >= MASK_IDX0) & (idx <= MASK_LAST);
    assign fi      = idx - FLAG_IDX0;
    assign mi      = idx - MASK_IDX0;
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pwrite & ~st_reg.err;
    assign rd_acc  = psel & penable & ~pwrite & ~st_reg.err;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = cond_in;
        st_next.s2 = st_reg.s1;
        ev         = '0;
        w1c        = '0;

        // Read data and error are prepared in the setup cycle so that
        // prdata comes from a flip-flop with no wait state.
        if (setup)
        begin
            st_next.rdata = 8'h00;
            st_next.err   = 1'b0;
            if (is_flag)
            begin
                st_next.rdata = st_reg.flag[fi[3:0]];
                st_next.err   = pwrite;
            end
            else if (is_mask)
                st_next.rdata = st_reg.mask[mi[3:0]];
            else if (hi_ok && idx == STAT_IDX)
            begin
                st_next.rdata[STAT_INIT] = st_reg.init;
                st_next.err = pwrite;
            end
            else if (hi_ok && idx == LOS_IDX)
            begin
                st_next.rdata = st_reg.s2[LOS_BYTE];
                st_next.err   = pwrite;
            end
            else if (hi_ok && idx == CTRL_IDX)
                st_next.rdata[CTRL_FAST] = st_reg.fast;
            else if (hi_ok && idx == RATE_IDX)
                st_next.rdata = st_reg.rate;
            else if (hi_ok && idx == IST_IDX)
                st_next.rdata[IRQ_W-1:0] = st_reg.ist;
            else if (hi_ok && idx == IMSK_IDX)
                st_next.rdata[IRQ_W-1:0] = st_reg.imsk;
            else
                st_next.err = 1'b1;
        end

        // Software writes.
        if (wr_acc)
        begin
            if (is_mask)
                st_next.mask[mi[3:0]] = pwdata[7:0];
            if (hi_ok && idx == CTRL_IDX)
                st_next.fast = pwdata[CTRL_FAST];
            if (hi_ok && idx == RATE_IDX)
                st_next.rate = pwdata[7:0];
            if (hi_ok && idx == IST_IDX)
                w1c = pwdata[IRQ_W-1:0];
            if (hi_ok && idx == IMSK_IDX)
                st_next.imsk = pwdata[IRQ_W-1:0];
        end

        for (int b = 0; b < NBYTE; b++)
        begin
            // latch raised conditions
            // A condition present in the clearing cycle wins.
            if (rd_acc && is_flag && fi == 8'(b))
                st_next.flag[b] = st_reg.s2[b];
            else
                st_next.flag[b] = st_reg.flag[b] | st_reg.s2[b];
        end
        if (st_reg.init)
            st_next.flag = '0;
        else
            ev[EV_NEW_FLAG] = |(st_reg.s2 & ~st_reg.flag);

        if (rst_c.held)
        begin
            st_next.init = 1'b1;
            st_next.icnt = '0;
            st_next.mask = '{default: MASK_RST};
            st_next.rate = RATE_RST;
            st_next.fast = 1'b0;
        end
        else if (st_reg.init)
        begin
            st_next.icnt = st_reg.icnt + IW'(1);
            if (st_reg.icnt == IW'(INIT_CYCLES - 1))
            begin
                st_next.init = 1'b0;
                ev[EV_INIT_DONE] = 1'b1;
            end
        end
        ev[EV_MOD_RESET] = rst_c.valid_rise;

        st_next.int_n = st_reg.init | ~|(st_reg.flag & ~st_reg.mask);

        // Sticky events; a new event beats a clear in the same cycle.
        st_next.ist = (st_reg.ist & ~w1c) | ev;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg       <= '0;
            st_reg.init  <= 1'b1;
            st_reg.int_n <= 1'b1;
            st_reg.mask  <= '{default: MASK_RST};
            st_reg.rate  <= RATE_RST;
        end
        else
            st_reg <= st_next;
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata                = {24'h000000, st_reg.rdata};
    assign pready                = 1'b1;
    assign pslverr               = psel & penable & st_reg.err;
    assign interrupt_out_n       = st_reg.int_n;
    assign management_init_state = st_reg.init;
    assign rate_sel              = st_reg.rate;
    assign fast_mode             = st_reg.fast;
    assign irq                   = |(st_reg.ist & ~st_reg.imsk);

    // ==========================================================
    // Checks
    // ==========================================================
    logic [7:0] fi_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fi_q <= 8'h00;
        else
            fi_q <= fi;
    end

    sequence s_flag_rd;
        rd_acc && is_flag && st_reg.s2 == '0;
    endsequence

    sequence s_mask_wr;
        wr_acc && is_mask;
    endsequence

    sequence s_rate_wr;
        wr_acc && hi_ok && idx == RATE_IDX;
    endsequence

    chk_init_bounded : assert property (
        @(posedge pclk) disable iff (!presetn)
        st_reg.init && !rst_c.held |-> st_reg.icnt < IW'(INIT_CYCLES))
        else $error("Init window overran its bound.");

    chk_init_restart : assert property (
        @(posedge pclk) disable iff (!presetn)
        rst_c.held |=> st_reg.init && st_reg.icnt == '0)
        else $error("Module reset did not restart init.");

    chk_flag_latch : assert property (
        @(posedge pclk) disable iff (!presetn)
        !st_reg.init && !rst_c.held
        |=> (st_reg.flag & $past(st_reg.s2)) == $past(st_reg.s2))
        else $error("Raised condition not latched.");

    chk_irq_assert : assert property (
        @(posedge pclk) disable iff (!presetn)
        !st_reg.init && |(st_reg.flag & ~st_reg.mask)
        |=> !interrupt_out_n)
        else $error("Interrupt pin not pulled low.");

    chk_irq_release : assert property (
        @(posedge pclk) disable iff (!presetn)
        !(|(st_reg.flag & ~st_reg.mask)) |=> interrupt_out_n)
        else $error("Interrupt pin held low without cause.");

    chk_read_clear : assert property (
        @(posedge pclk) disable iff (!presetn)
        s_flag_rd ##1 1 |-> st_reg.flag[fi_q[3:0]] == 8'h00)
        else $error("Flag byte not cleared by read.");

    chk_mask_store : assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_mask_wr and !rst_c.held)
        |=> st_reg.mask[fi_q[3:0] - 4'(MASK_IDX0 - FLAG_IDX0)]
            == $past(pwdata[7:0]))
        else $error("Mask write not stored.");

    chk_rate_apply : assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_rate_wr and !rst_c.held) |=> rate_sel == $past(pwdata[7:0]))
        else $error("Rate select not applied.");

    chk_los_live : assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && hi_ok && idx == LOS_IDX
        |=> prdata[7:0] == $past(st_reg.s2[LOS_BYTE]))
        else $error("Loss status not live.");

    chk_flag_ro : assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && pwrite && is_flag |=> pslverr)
        else $error("Write to flag area not refused.");
endmodule : msi_core

/* rtl/msi_pkg.sv */
/*
 Constants for the module status and interrupt block: register indexes,
 field positions, reset values and timing counts.
 Assumes a 100 MHz management clock; register byte address is four times
 the index.
*/
package msi_pkg;
    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_MHZ        = 100;
    localparam int RESET_MIN_US   = 2;
    localparam int RESET_MIN_CYC  = RESET_MIN_US * CLK_MHZ;
    localparam int INIT_MAX_MS    = 2000;
    localparam int INIT_MAX_CYC   = INIT_MAX_MS * 1000 * CLK_MHZ;
    // ==========================================================
    // Flag and mask areas
    // ==========================================================
    localparam int NBYTE          = 15;
    localparam int ADDR_W         = 12;
    localparam logic [7:0] FLAG_IDX0  = 8'h03;
    localparam logic [7:0] FLAG_LAST  = 8'h11;
    localparam logic [7:0] MASK_IDX0  = 8'h66;
    localparam logic [7:0] MASK_LAST  = 8'h74;
    localparam logic [7:0] MASK_RST   = 8'h00;
    // ==========================================================
    // Own registers
    // ==========================================================
    localparam logic [7:0] STAT_IDX   = 8'h12;
    localparam logic [7:0] LOS_IDX    = 8'h13;
    localparam logic [7:0] CTRL_IDX   = 8'h56;
    localparam logic [7:0] RATE_IDX   = 8'h57;
    localparam logic [7:0] IST_IDX    = 8'h75;
    localparam logic [7:0] IMSK_IDX   = 8'h76;
    localparam int LOS_BYTE       = 0;
    localparam int CTRL_FAST      = 0;
    localparam int STAT_INIT      = 0;
    localparam logic [7:0] RATE_RST   = 8'h00;
    // Event bits of the sticky interrupt status register.
    localparam int IRQ_W          = 3;
    localparam int EV_INIT_DONE   = 0;
    localparam int EV_MOD_RESET   = 1;
    localparam int EV_NEW_FLAG    = 2;
endpackage : msi_pkg

/* rtl/msi_rst_if.sv */
/*
 Carrier from the module reset filter to the status core.
 Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface msi_rst_if;
    logic held;
    logic valid_rise;
    modport src (output held, output valid_rise);
    modport snk (input held, input valid_rise);
endinterface : msi_rst_if

/* rtl/msi_rst_filter.sv */
/*
 Module reset pin filter: synchronises the active-low reset pin, measures
 its low time and reports a valid reset request.
 Assumes the pin idles high and is asynchronous to pclk.
*/
`timescale 1ns/1ps
module msi_rst_filter
    import msi_pkg::*;
#(
    parameter int MIN_CYC = RESET_MIN_CYC
)(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and carrier
    input  wire logic module_reset_n,
    msi_rst_if.src    rst
);
    localparam int CW = $clog2(MIN_CYC + 1);
    initial
    begin
        if (MIN_CYC < 1) $error("MIN_CYC must be at least one");
    end

    typedef struct packed {
        logic          s1;
        logic          s2;
        logic          prev;
        logic [CW-1:0] cnt;
        logic          rise;
    } msi_flt_st_t;

    msi_flt_st_t st_reg;
    msi_flt_st_t st_next;

    // ==========================================================
    // Low-time counter
    // ==========================================================
    always_comb
    begin
        st_next      = st_reg;
        st_next.s1   = module_reset_n;
        st_next.s2   = st_reg.s1;
        st_next.prev = st_reg.s2;
        if (st_reg.s2)
            st_next.cnt = '0;
        else if (st_reg.cnt != CW'(MIN_CYC))
            st_next.cnt = st_reg.cnt + CW'(1);
        st_next.rise = st_reg.s2 & ~st_reg.prev
                     & (st_reg.cnt == CW'(MIN_CYC));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_reg <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, cnt: '0,
                        rise: 1'b0};
        else
            st_reg <= st_next;
    end

    // Shorter glitches are ignored, so noise on the pin cannot reset.
    assign rst.held       = ~st_reg.s2 & (st_reg.cnt == CW'(MIN_CYC));
    assign rst.valid_rise = st_reg.rise;

    chk_reset_valid_len : assert property (
        @(posedge pclk) disable iff (!presetn)
        rst.valid_rise |-> $past(st_reg.cnt, 1) == CW'(MIN_CYC))
        else $error("Reset accepted after a short pulse.");
endmodule : msi_rst_filter

/* dv/msi_front_model.sv */
/*
 Far-side model of the module pins: the host's reset pin and the optical
 front end's flag conditions.
 Assumes the bench calls its tasks from one process, off no other edge.
*/
`timescale 1ns/1ps
module msi_front_model
    import msi_pkg::*;
(
    // Clock
    input  wire logic                 pclk,
    // Pins toward the core
    output logic                      module_reset_n,
    output logic      [NBYTE*8-1:0]   cond_in
);
    initial
    begin
        module_reset_n = 1'b1;
        cond_in        = '0;
    end

    // ==========================================================
    // Reset pin
    // ==========================================================
    // host reset pulse
    // The length is a parameter of the call so that too short pulses can
    // be tried as well.
    task automatic pulse_reset(input int cyc);
        @(posedge pclk);
        module_reset_n <= 1'b0;
        repeat (cyc) @(posedge pclk);
        module_reset_n <= 1'b1;
    endtask : pulse_reset

    // ==========================================================
    // Flag conditions
    // ==========================================================
    task automatic set_cond(input int b, input logic [7:0] v);
        @(posedge pclk);
        cond_in[8*b +: 8] <= v;
    endtask : set_cond
endmodule : msi_front_model

/* dv/test_module_status_interrupt_timing.sv */
/*
 Self-checking bench of the status and interrupt core over APB.
 Assumes zero wait states are not relied on and a shortened init count.
*/
`timescale 1ns/1ps
`define CHK(act, exp) \
    begin \
        check_count++; \
        if ((act) !== (exp)) \
        begin \
            fails++; \
            $display("unexpected at %0t: got %h want %h", $time, act, exp); \
        end \
    end
module test_module_status_interrupt_timing
    import msi_pkg::*;
;
    localparam int INIT_SIM = 50;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              module_reset_n;
    logic              interrupt_out_n;
    logic [NBYTE*8-1:0] cond_in;
    logic              management_init_state;
    logic [7:0]        rate_sel;
    logic              fast_mode;
    logic              irq;
    int                fails = 0;
    int                check_count = 0;
    logic [31:0]       rd;
    logic              err;
    logic [7:0]        bm;
    int                b;
    int                blist [4] = '{0, 1, 5, 14};

    always #5 pclk = ~pclk;

    msi_core #(.INIT_CYCLES(INIT_SIM)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .module_reset_n(module_reset_n), .interrupt_out_n(interrupt_out_n),
        .cond_in(cond_in), .management_init_state(management_init_state),
        .rate_sel(rate_sel), .fast_mode(fast_mode), .irq(irq)
    );
    msi_front_model i_front (
        .pclk(pclk), .module_reset_n(module_reset_n), .cond_in(cond_in)
    );

    // ==========================================================
    // Bus and helper tasks
    // ==========================================================
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // The access ends at the rising edge that sees pready high; data
        // and response are taken there, before the registers update.
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        `CHK(rd, {24'h000000, exp})
    endtask : rd_chk

    function automatic logic pick(input int w);
        return (w == 0) ? interrupt_out_n :
               (w == 1) ? management_init_state : irq;
    endfunction : pick

    task automatic wait_for(input int w, input logic lvl, input int max);
        int n;
        n = 0;
        while (pick(w) !== lvl && n < max)
        begin
            @(negedge pclk);
            n++;
        end
        `CHK(pick(w), lvl)
    endtask : wait_for

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Tests
    // ==========================================================
    initial
    begin
        repeat (8) @(posedge pclk);
        `CHK({interrupt_out_n, management_init_state, rate_sel, irq}, 11'h600)
        presetn <= 1'b1;
        rd_chk(MASK_IDX0, MASK_RST);
        wait_for(1, 1'b0, INIT_SIM + 30);
        rd_chk(STAT_IDX, 8'h00);
        rd_chk(IST_IDX, 8'h01);
        wait_for(2, 1'b1, 4);
        apb(1'b1, IMSK_IDX, 32'h7);
        wait_for(2, 1'b0, 4);
        apb(1'b1, IST_IDX, 32'h1);
        apb(1'b1, IMSK_IDX, 32'h0);
        rd_chk(IST_IDX, 8'h00);
        $display("test init and status done");

        apb(1'b1, CTRL_IDX, 32'h1 << CTRL_FAST);
        @(negedge pclk);
        `CHK(fast_mode, 1'b1)
        foreach (blist[k])
        begin
            b  = blist[k];
            bm = 8'h01 << (b % 8);
            i_front.set_cond(b, bm);
            wait_for(0, 1'b0, 10);
            rd_chk(FLAG_IDX0 + 8'(b), bm);
            rd_chk(LOS_IDX, (b == LOS_BYTE) ? bm : 8'h00);
            i_front.set_cond(b, 8'h00);
            repeat (4) @(posedge pclk);
            `CHK(interrupt_out_n, 1'b0)
            rd_chk(LOS_IDX, 8'h00);
            rd_chk(FLAG_IDX0 + 8'(b), bm);
            wait_for(0, 1'b1, 6);
            rd_chk(FLAG_IDX0 + 8'(b), 8'h00);
        end
        rd_chk(IST_IDX, 8'h04);
        apb(1'b1, IST_IDX, 32'h4);
        $display("test flags done");

        i_front.set_cond(1, 8'h01);
        wait_for(0, 1'b0, 10);
        apb(1'b1, MASK_IDX0 + 8'h01, 32'h1);
        wait_for(0, 1'b1, 6);
        rd_chk(MASK_IDX0 + 8'h01, 8'h01);
        apb(1'b1, MASK_IDX0 + 8'h01, 32'h2);
        wait_for(0, 1'b0, 6);
        repeat (4) @(posedge pclk);
        `CHK(interrupt_out_n, 1'b0)
        apb(1'b1, MASK_IDX0 + 8'h01, 32'h0);
        i_front.set_cond(1, 8'h00);
        repeat (4) @(posedge pclk);
        rd_chk(FLAG_IDX0 + 8'h01, 8'h01);
        wait_for(0, 1'b1, 6);
        $display("test masks done");

        apb(1'b1, RATE_IDX, 32'hA5);
        repeat (2) @(posedge pclk);
        `CHK(rate_sel, 8'hA5)
        rd_chk(RATE_IDX, 8'hA5);
        apb(1'b1, FLAG_IDX0, 32'hFF);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        $display("test registers done");

        i_front.pulse_reset(RESET_MIN_CYC / 2);
        repeat (6) @(posedge pclk);
        `CHK(management_init_state, 1'b0)
        i_front.pulse_reset(RESET_MIN_CYC + 20);
        @(negedge pclk);
        `CHK({management_init_state, rate_sel, fast_mode}, 10'h200)
        wait_for(1, 1'b0, INIT_SIM + 30);
        rd_chk(IST_IDX, 8'h07);
        $display("test module reset done");
        end_of_test();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : test_module_status_interrupt_timing
